// file: src/lec_pkg.sv
/*
  Package for the link enhancement control block: register offset, reset value,
  field positions, threshold codes, stream format codes and the FIFO word carrier.
  Assumes a 32-bit configuration access path with byte enables.
*/
package lec_pkg;

  // Register placement and layout
  localparam logic [7:0]  LEC_CTRL_OFFSET = 8'hF4;
  localparam logic [31:0] LEC_CTRL_RESET  = 32'h0000_1000;
  localparam logic [31:0] LEC_CTRL_WMASK  = 32'h0000_B582;

  localparam int unsigned BIT_PIPE_OFF   = 15;
  localparam int unsigned BIT_THR_LO     = 12;
  localparam int unsigned BIT_MPEG_STAMP = 10;
  localparam int unsigned BIT_DV_STAMP   = 8;
  localparam int unsigned BIT_PRIORITY   = 7;
  localparam int unsigned BIT_ACCEL      = 1;

  // Threshold field codes
  localparam logic [1:0] THR_STORE_FWD = 2'h0;
  localparam logic [1:0] THR_1K7       = 2'h1;
  localparam logic [1:0] THR_1K        = 2'h2;
  localparam logic [1:0] THR_512       = 2'h3;

  // Threshold as a fraction of the FIFO depth, in 32nds (2 KB maps to the full FIFO)
  localparam int unsigned THR_FRAC_DEN  = 32;
  localparam int unsigned THR_FRAC_1K7  = 27;
  localparam int unsigned THR_FRAC_1K   = 16;
  localparam int unsigned THR_FRAC_512  = 8;

  // Isochronous stream format codes
  localparam logic [7:0] CIP_FORMAT_MPEG = 8'h20;
  localparam logic [7:0] CIP_FORMAT_DV   = 8'h00;

  localparam int unsigned TX_FIFO_DEPTH = 16;

  typedef struct packed {
    logic        last;
    logic [31:0] data;
  } lec_word_type;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SEND  = 2'b01,
    TX_FLUSH = 2'b10
  } lec_txstate_type;

endpackage : lec_pkg

// file: src/link_enhancement_control.sv
/*
  Link enhancement control register with the asynchronous transmit threshold
  engine and its transmit FIFO. Holds lec_fifo and the top module.
  Assumes a configuration access port (address, byte enables, strobes), an
  EEPROM loader strobe, a transmit word stream with an end-of-packet flag and a
  link consumer that signals ready. All inputs are synchronous to mclk.
*/
// Operation
// - Enhancement bits act only while the phy enhancement gate input is high.
// - Bits 31 to 16 read zero and ignore writes.
// - Pipeline-off bit stops out-of-order async transmit pipelining.
// - Threshold field: 00 full packet, 01 default 1.7K, 10 1K, 11 512 bytes.
// - Programmed threshold holds until an underrun; the retry is store-and-forward.
// - Transmit starts at threshold fill or when a whole packet is buffered.
// - FIFO empty mid-packet flags packet error, then store-and-forward retransmit.
// - Store-and-forward sends nothing until the packet end token is buffered.
// - Zero retry count forces store-and-forward regardless of the threshold field.
// - MPEG stamp bit enables stamping for streams with format code 20h.
// - DV stamp bit enables stamping for streams with format code 00h.
// - Priority bit makes the link answer requests with priority arbitration.
// - Bits 11 and 9 read as zero.
// - Register loads from host writes or from an attached serial EEPROM.
// - Acceleration bit tells the PHY the link supports acceleration enhancements.
// - Bits 6, 5 to 2 and 0 read zero and ignore writes.
`timescale 1ns/1ps

module lec_fifo #(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [WIDTH-1:0]                outData,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned LW = $clog2(DEPTH+1);

  generate
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("lec_fifo depth must be a power of two of at least 4");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r, wrPtr_nxt;
  logic [AW-1:0]    rdPtr_r, rdPtr_nxt;
  logic [LW-1:0]    count_r, count_nxt;
  logic             push, pop;
  // Registered so txReady leaves the top straight from a flop
  logic             ready_r, ready_nxt;

  always_comb
  begin
    inReady   = ready_r;
    outValid  = (count_r != '0);
    outData   = mem[rdPtr_r];
    level     = count_r;
    push      = inValid && inReady;
    pop       = outValid && outReady;
    wrPtr_nxt = push ? wrPtr_r + AW'(1) : wrPtr_r;
    rdPtr_nxt = pop ? rdPtr_r + AW'(1) : rdPtr_r;
    count_nxt = count_r + LW'(push) - LW'(pop);
    ready_nxt = (count_nxt != LW'(DEPTH));
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b1;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      ready_r <= ready_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wrPtr_r] <= inData;
    end
  end

endmodule : lec_fifo

module link_enhancement_control #(
  parameter int unsigned DEPTH = lec_pkg::TX_FIFO_DEPTH
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  // Configuration access
  input  wire logic [7:0]          cfgAddr,
  input  wire logic                cfgWrite,
  input  wire logic                cfgRead,
  input  wire logic [3:0]          cfgByteEn,
  input  wire logic [31:0]         cfgWrData,
  output logic [31:0]              cfgRdData,
  // Serial EEPROM loader
  input  wire logic                eepromLoad,
  input  wire logic [31:0]         eepromData,
  // Surrounding controller state
  input  wire logic                phyEnhancementGate,
  input  wire logic                retriesZero,
  input  wire logic [7:0]          cipFormatCode,
  // Transmit stream into the FIFO
  input  wire logic                txValid,
  output logic                     txReady,
  input  wire lec_pkg::lec_word_type txWord,
  // Link side
  output logic                     linkValid,
  input  wire logic                linkReady,
  output lec_pkg::lec_word_type    linkWord,
  output logic                     pktError,
  output logic                     storeForward,
  output logic                     txPipelineOff,
  output logic                     stampApply,
  output logic                     priorityArb,
  output logic                     accelSupport
);
  localparam int unsigned LW = $clog2(DEPTH+1);
  localparam int unsigned WW = $bits(lec_pkg::lec_word_type);

  generate
    if (DEPTH < 4)
    begin : g_bad_depth
      $error("link_enhancement_control depth must be at least 4");
    end
  endgenerate

  // Fill level at which cut-through transmit may start
  function automatic logic [LW-1:0] thrWords(input logic [1:0] code);
    unique case (code)
      lec_pkg::THR_1K7: thrWords = LW'(DEPTH * lec_pkg::THR_FRAC_1K7 / lec_pkg::THR_FRAC_DEN);
      lec_pkg::THR_1K:  thrWords = LW'(DEPTH * lec_pkg::THR_FRAC_1K / lec_pkg::THR_FRAC_DEN);
      lec_pkg::THR_512: thrWords = LW'(DEPTH * lec_pkg::THR_FRAC_512 / lec_pkg::THR_FRAC_DEN);
      lec_pkg::THR_STORE_FWD: thrWords = LW'(DEPTH);
    endcase
  endfunction : thrWords

  // Register bank
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [31:0] beMask;

  always_comb
  begin
    beMask   = {{8{cfgByteEn[3]}}, {8{cfgByteEn[2]}}, {8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};
    ctrl_nxt = ctrl_r;
    if (eepromLoad)
    begin
      ctrl_nxt = eepromData & lec_pkg::LEC_CTRL_WMASK;
    end
    // A host write in the same cycle overrides the loader in the bytes it enables
    if (cfgWrite && cfgAddr == lec_pkg::LEC_CTRL_OFFSET)
    begin
      ctrl_nxt = (ctrl_nxt & ~(beMask & lec_pkg::LEC_CTRL_WMASK))
               | (cfgWrData & beMask & lec_pkg::LEC_CTRL_WMASK);
    end
    rd_nxt = '0;
    if (cfgRead && cfgAddr == lec_pkg::LEC_CTRL_OFFSET)
    begin
      rd_nxt = ctrl_r & lec_pkg::LEC_CTRL_WMASK;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_r <= lec_pkg::LEC_CTRL_RESET;
      rd_r   <= '0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign cfgRdData = rd_r;

  // Static enhancement outputs
  logic [1:0] thrCode;
  logic       pipeOff_r, stamp_r, prio_r, accel_r;

  assign thrCode = ctrl_r[lec_pkg::BIT_THR_LO +: 2];

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pipeOff_r <= 1'b0;
      stamp_r   <= 1'b0;
      prio_r    <= 1'b0;
      accel_r   <= 1'b0;
    end
    else
    begin
      pipeOff_r <= phyEnhancementGate && ctrl_r[lec_pkg::BIT_PIPE_OFF];
      stamp_r   <= phyEnhancementGate
                && ((ctrl_r[lec_pkg::BIT_MPEG_STAMP] && cipFormatCode == lec_pkg::CIP_FORMAT_MPEG)
                 || (ctrl_r[lec_pkg::BIT_DV_STAMP] && cipFormatCode == lec_pkg::CIP_FORMAT_DV));
      prio_r    <= phyEnhancementGate && ctrl_r[lec_pkg::BIT_PRIORITY];
      accel_r   <= phyEnhancementGate && ctrl_r[lec_pkg::BIT_ACCEL];
    end
  end

  assign txPipelineOff = pipeOff_r;
  assign stampApply    = stamp_r;
  assign priorityArb   = prio_r;
  assign accelSupport  = accel_r;

  // Transmit FIFO
  logic                  fOutValid, fOutReady;
  lec_pkg::lec_word_type fOut;
  logic [WW-1:0]         fOutBits;
  logic [LW-1:0]         fLevel;
  logic                  pushLast;

  assign fOut     = lec_pkg::lec_word_type'(fOutBits);
  assign pushLast = txValid && txReady && txWord.last;

  lec_fifo #(
    .WIDTH (WW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .reset    (reset),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   (txWord),
    .outValid (fOutValid),
    .outReady (fOutReady),
    .outData  (fOutBits),
    .level    (fLevel)
  );

  // Threshold engine
  lec_pkg::lec_txstate_type state_r, state_nxt;
  logic [LW-1:0]         eop_r, eop_nxt;
  logic                  retrySf_r, retrySf_nxt;
  logic                  sfEff_r, sfEff_nxt;
  logic                  lv_r, lv_nxt;
  lec_pkg::lec_word_type lw_r, lw_nxt;
  logic                  err_r, err_nxt;
  logic                  slot, popLast;

  always_comb
  begin
    slot        = !lv_r || linkReady;
    fOutReady   = 1'b0;
    state_nxt   = state_r;
    retrySf_nxt = retrySf_r;
    lv_nxt      = lv_r && !linkReady;
    lw_nxt      = lw_r;
    err_nxt     = 1'b0;
    // Gate off means no enhancement, so fall back to whole-packet transmit
    sfEff_nxt   = retrySf_r || retriesZero || !phyEnhancementGate
               || thrCode == lec_pkg::THR_STORE_FWD;
    unique case (state_r)
      lec_pkg::TX_IDLE:
      begin
        if (fOutValid && (eop_r != '0 || (!sfEff_r && fLevel >= thrWords(thrCode))))
        begin
          state_nxt = lec_pkg::TX_SEND;
        end
      end
      lec_pkg::TX_SEND:
      begin
        if (slot && fOutValid)
        begin
          fOutReady = 1'b1;
          lv_nxt    = 1'b1;
          lw_nxt    = fOut;
          if (fOut.last)
          begin
            state_nxt   = lec_pkg::TX_IDLE;
            retrySf_nxt = 1'b0;
          end
        end
        else if (slot)
        begin
          err_nxt     = 1'b1;
          retrySf_nxt = 1'b1;
          state_nxt   = lec_pkg::TX_FLUSH;
        end
      end
      lec_pkg::TX_FLUSH:
      begin
        // Drop the rest of the failed packet; software resends it whole
        fOutReady = fOutValid;
        if (fOutValid && fOut.last)
        begin
          state_nxt = lec_pkg::TX_IDLE;
        end
      end
      default:
      begin
        state_nxt = lec_pkg::TX_IDLE;
      end
    endcase
    popLast = fOutReady && fOutValid && fOut.last;
    eop_nxt = eop_r + LW'(pushLast) - LW'(popLast);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_r   <= lec_pkg::TX_IDLE;
      eop_r     <= '0;
      retrySf_r <= 1'b0;
      sfEff_r   <= 1'b1;
      lv_r      <= 1'b0;
      lw_r      <= '0;
      err_r     <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      eop_r     <= eop_nxt;
      retrySf_r <= retrySf_nxt;
      sfEff_r   <= sfEff_nxt;
      lv_r      <= lv_nxt;
      lw_r      <= lw_nxt;
      err_r     <= err_nxt;
    end
  end

  assign linkValid    = lv_r;
  assign linkWord     = lw_r;
  assign pktError     = err_r;
  assign storeForward = sfEff_r;

endmodule : link_enhancement_control

// file: dv/lec_props.sv
/*
  Port checker for link_enhancement_control.
  Assumes one clock, mclk, and the synchronous reset input.
*/
`timescale 1ns/1ps
module lec_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [7:0]  cfgAddr,
  input wire logic        cfgWrite,
  input wire logic        cfgRead,
  input wire logic [3:0]  cfgByteEn,
  input wire logic [31:0] cfgWrData,
  input wire logic [31:0] cfgRdData,
  input wire logic        eepromLoad,
  input wire logic        phyEnhancementGate,
  input wire logic        retriesZero,
  input wire logic [7:0]  cipFormatCode,
  input wire logic        linkValid,
  input wire logic        pktError,
  input wire logic        storeForward,
  input wire logic        txPipelineOff,
  input wire logic        stampApply,
  input wire logic        priorityArb,
  input wire logic        accelSupport
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Host write with a quiet, gated cycle behind it
  sequence s_wr(int i);
    cfgWrite && cfgAddr == 8'hF4 && cfgByteEn[i] && !eepromLoad
    ##1 phyEnhancementGate && !cfgWrite && !eepromLoad;
  endsequence
  property p_rsvd;
    (cfgRdData & ~lec_pkg::LEC_CTRL_WMASK) == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_unmapped;
    cfgRead && cfgAddr != lec_pkg::LEC_CTRL_OFFSET |=> cfgRdData == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_gate;
    !phyEnhancementGate |=> !txPipelineOff && !priorityArb && !accelSupport && !stampApply && storeForward;
  endproperty
  a_gate: assert property (p_gate) else $error("enhancement active without gate");
  property p_retry;
    retriesZero |=> storeForward;
  endproperty
  a_retry: assert property (p_retry) else $error("no store-and-forward at zero retries");
  property p_err;
    pktError |=> !pktError ##[0:1] storeForward;
  endproperty
  a_err: assert property (p_err) else $error("underrun not followed by store-and-forward");
  property p_accel;
    s_wr(0) |=> accelSupport == $past(cfgWrData[1], 2);
  endproperty
  a_accel: assert property (p_accel) else $error("acceleration level wrong");
  property p_prio;
    s_wr(0) |=> priorityArb == $past(cfgWrData[7], 2);
  endproperty
  a_prio: assert property (p_prio) else $error("priority level wrong");
  property p_pipe;
    s_wr(1) |=> txPipelineOff == $past(cfgWrData[15], 2);
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline-off level wrong");
  property p_stamp;
    stampApply |-> $past(phyEnhancementGate) && ($past(cipFormatCode) == lec_pkg::CIP_FORMAT_MPEG
      || $past(cipFormatCode) == lec_pkg::CIP_FORMAT_DV);
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamping on a foreign stream");
  c_err: cover property (pktError);
  c_stamp: cover property (stampApply);
  c_send: cover property (linkValid && !storeForward);
endmodule : lec_props

bind link_enhancement_control lec_props u_props (.mclk, .reset, .cfgAddr, .cfgWrite, .cfgRead,
  .cfgByteEn, .cfgWrData, .cfgRdData, .eepromLoad, .phyEnhancementGate, .retriesZero, .cipFormatCode,
  .linkValid, .pktError, .storeForward, .txPipelineOff, .stampApply, .priorityArb, .accelSupport);

// file: dv/lec_link_sink.sv
/*
  Link consumer model: prompt, stalled or every other cycle.
  Assumes the design holds linkWord until linkReady.
*/
`timescale 1ns/1ps
module lec_link_sink (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [1:0] mode,
  input  wire logic       linkValid,
  output logic            linkReady,
  output logic [7:0]      rxCount
);
  logic phase;
  // Stall mode lets the FIFO fill, so thresholds are seen without underrun
  assign linkReady = mode == 2'h0 || (mode == 2'h2 && phase);
  always_ff @(posedge mclk)
  begin
    phase <= reset ? 1'b0 : ~phase;
    rxCount <= reset ? 8'h00 : rxCount + 8'(linkValid && linkReady);
  end
endmodule : lec_link_sink

// file: dv/test_link_enhancement_control.sv
/*
  Testbench for link_enhancement_control: register, levels, thresholds.
  Assumes lec_link_sink on the link side and lec_props bound.
*/
`timescale 1ns/1ps
module test_link_enhancement_control;
  localparam int DEPTH = 16;
  logic                  mclk, reset, cfgWrite, cfgRead, eepromLoad, phyEnhancementGate;
  logic                  retriesZero, txValid, txReady, linkValid, linkReady, pktError, storeForward;
  logic                  txPipelineOff, stampApply, priorityArb, accelSupport;
  logic [7:0]            cfgAddr, cipFormatCode, rxCount;
  logic [3:0]            cfgByteEn;
  logic [31:0]           cfgWrData, cfgRdData, eepromData;
  logic [1:0]            mode;
  lec_pkg::lec_word_type txWord, linkWord;
  int                    err_total, n_checks, seq, exp, n, first;
  int                    fr [4] = '{0, lec_pkg::THR_FRAC_1K7, lec_pkg::THR_FRAC_1K, lec_pkg::THR_FRAC_512};
  link_enhancement_control #(.DEPTH(DEPTH)) uut (.mclk, .reset, .cfgAddr, .cfgWrite, .cfgRead,
    .cfgByteEn, .cfgWrData, .cfgRdData, .eepromLoad, .eepromData, .phyEnhancementGate, .retriesZero,
    .cipFormatCode, .txValid, .txReady, .txWord, .linkValid, .linkReady, .linkWord, .pktError,
    .storeForward, .txPipelineOff, .stampApply, .priorityArb, .accelSupport);
  lec_link_sink sink (.mclk, .reset, .mode, .linkValid, .linkReady, .rxCount);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  task chk(input string nm, input logic [32:0] seen, input logic [32:0] want);
    n_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task summarize;
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    {cfgAddr, cfgByteEn, cfgWrData, cfgWrite} = {a, b, d, 1'b1};
    tick(1);
    cfgWrite = 1'b0;
    // A quiet edge keeps back-to-back calls from toggling the strobe in one step
    tick(1);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] want);
    {cfgAddr, cfgRead} = {a, 1'b1};
    tick(1);
    cfgRead = 1'b0;
    chk("cfgRdData", cfgRdData, want);
    tick(1);
  endtask : rd
  // Hung handshakes end the run as a mismatch
  task push(input int cnt, input logic lst);
    int k;
    txValid = 1'b1;
    for (int i = 1; i <= cnt; i++)
    begin
      txWord = {lst && i == cnt, seq[31:0]};
      seq++;
      for (k = 0; txReady !== 1'b1 && k < 60; k++) tick(1);
      if (k == 60)
      begin
        chk("txReady wait", 1'b0, 1'b1);
        summarize;
      end
      tick(1);
    end
    txValid = 1'b0;
  endtask : push
  task waitv(input logic err, input int cnt, input logic want);
    logic got;
    got = 1'b0;
    repeat (cnt)
    begin
      got = got | ((err ? pktError : linkValid) === 1'b1);
      tick(1);
    end
    chk(err ? "pktError" : "linkValid", got, want);
  endtask : waitv
  task drain(input int want);
    int k;
    for (k = 0; rxCount != want && k < 300; k++) tick(1);
    chk("rxCount", rxCount, want);
    if (k == 300)
    begin
      summarize;
    end
  endtask : drain
  initial
  begin
    {reset, mode, txWord, cfgAddr, cfgByteEn, cfgWrData, eepromData, cipFormatCode} = '0;
    {cfgWrite, cfgRead, eepromLoad, phyEnhancementGate, retriesZero, txValid} = '0;
    {err_total, n_checks, seq, exp} = '0;
    reset = 1'b1;
    tick(8);
    reset = 1'b0;
    rd(8'hF4, lec_pkg::LEC_CTRL_RESET);
    wr(8'hF4, 4'hF, 32'hFFFF_FFFF);
    rd(8'hF4, 32'h0000_B582);
    wr(8'hF4, 4'h2, 32'h0000_0000);
    rd(8'hF4, 32'h0000_0082);
    wr(8'hF0, 4'hF, 32'h0000_0000);
    rd(8'hF0, 32'h0000_0000);
    rd(8'hF4, 32'h0000_0082);
    {eepromData, eepromLoad} = {32'hFFFF_5182, 1'b1};
    tick(1);
    eepromLoad = 1'b0;
    rd(8'hF4, 32'h0000_1182);
    phyEnhancementGate = 1'b1;
    wr(8'hF4, 4'hF, 32'h0000_8082);
    tick(2);
    chk("levels", {txPipelineOff, priorityArb, accelSupport}, 3'h7);
    phyEnhancementGate = 1'b0;
    tick(2);
    chk("levels", {txPipelineOff, priorityArb, accelSupport, storeForward}, 4'h1);
    phyEnhancementGate = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cipFormatCode = (i == 1 || i == 2) ? lec_pkg::CIP_FORMAT_DV : lec_pkg::CIP_FORMAT_MPEG;
      wr(8'hF4, 4'hF, i < 2 ? 32'h0000_0400 : 32'h0000_0100);
      tick(2);
      chk("stampApply", stampApply, i % 2 == 0);
    end
    for (int c = 0; c < 4; c++)
    begin
      n = c == 0 ? 5 : fr[c] * DEPTH / lec_pkg::THR_FRAC_DEN;
      mode = 2'h1;
      wr(8'hF4, 4'hF, 32'(c) << 12);
      first = seq;
      push(n - 1, 1'b0);
      waitv(1'b0, 12, 1'b0);
      push(1, c == 0);
      waitv(1'b0, 12, 1'b1);
      chk("linkWord", linkWord.data, first);
      if (c != 0) push(1, 1'b1);
      mode = 2'h0;
      exp += n + (c != 0);
      drain(exp);
    end
    wr(8'hF4, 4'hF, 32'h0000_3000);
    push(4, 1'b0);
    waitv(1'b1, 30, 1'b1);
    chk("storeForward", storeForward, 1'b1);
    push(1, 1'b1);
    tick(4);
    // The four buffered words go out before the underrun; the dropped tail never does
    exp += 4;
    push(4, 1'b0);
    waitv(1'b0, 12, 1'b0);
    push(1, 1'b1);
    exp += 5;
    drain(exp);
    tick(3);
    chk("storeForward", storeForward, 1'b0);
    {retriesZero, mode} = {1'b1, 2'h1};
    push(DEPTH - 1, 1'b0);
    waitv(1'b0, 3, 1'b0);
    chk("storeForward", storeForward, 1'b1);
    push(1, 1'b1);
    chk("txReady", txReady, 1'b0);
    mode = 2'h2;
    exp += DEPTH;
    drain(exp);
    summarize;
  end
endmodule : test_link_enhancement_control
